// file: include/ufdma_pkg.sv
// Constants and types for the UART FIFO control and DMA ready block
package ufdma_pkg;

   // Register port geometry
   localparam int UFDMA_DATA_W = 8;
   localparam int UFDMA_ADDR_W = 3;

   // Register offsets on the plain register port
   localparam logic [2:0] UFDMA_OFS_HOLD = 3'h0;
   localparam logic [2:0] UFDMA_OFS_CTRL = 3'h1;
   localparam logic [2:0] UFDMA_OFS_RXCNT = 3'h2;
   localparam logic [2:0] UFDMA_OFS_TXCNT = 3'h3;
   localparam logic [2:0] UFDMA_OFS_FLAGS = 3'h4;

   // Reset values
   localparam logic [7:0] UFDMA_CTRL_RST = 8'h00;
   localparam logic [7:0] UFDMA_RDATA_RST = 8'h00;

   // Receive trigger select codes and the occupancy each one selects
   localparam logic [1:0] UFDMA_TRIG_SEL_1 = 2'h0;
   localparam logic [1:0] UFDMA_TRIG_SEL_4 = 2'h1;
   localparam logic [1:0] UFDMA_TRIG_SEL_8 = 2'h2;
   localparam logic [1:0] UFDMA_TRIG_SEL_14 = 2'h3;
   localparam logic [7:0] UFDMA_TRIG_LVL_1 = 8'h01;
   localparam logic [7:0] UFDMA_TRIG_LVL_4 = 8'h04;
   localparam logic [7:0] UFDMA_TRIG_LVL_8 = 8'h08;
   localparam logic [7:0] UFDMA_TRIG_LVL_14 = 8'h0E;

   // Field positions of the flags register
   localparam int UFDMA_FLAG_TRIG = 0;
   localparam int UFDMA_FLAG_RX_RDY_N = 1;
   localparam int UFDMA_FLAG_TX_RDY_N = 2;
   localparam int UFDMA_FLAG_FIFO_EN = 3;
   localparam int UFDMA_FLAG_DMA_MODE = 4;
   localparam int UFDMA_FLAG_TX_FULL = 5;
   localparam int UFDMA_FLAG_RX_FULL = 6;

   // Layout of the fifo_control register, bit 7 first
   typedef struct packed {
      logic [1:0] rx_trig_sel;
      logic [1:0] unused;
      logic dma_mode;
      logic tx_flush;
      logic rx_flush;
      logic fifo_en;
   } ufdma_ctrl_s;

endpackage : ufdma_pkg

// file: hdl/ufdma_top.sv
// FIFO control, receive trigger and DMA ready pins for one UART channel
`timescale 1ns/1ps
`default_nettype none

module ufdma_top
   import ufdma_pkg::*;
#(
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_n_in,
   // Register port
   input wire logic [UFDMA_ADDR_W-1:0] addr_in,
   input wire logic [UFDMA_DATA_W-1:0] wr_data_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [UFDMA_DATA_W-1:0] rd_data_out,
   // Transmit shift register side
   input wire logic tx_pop_in,
   output logic [UFDMA_DATA_W-1:0] tx_data_out,
   output logic tx_valid_out,
   // Receive shift register side
   input wire logic rx_push_in,
   input wire logic [UFDMA_DATA_W-1:0] rx_data_in,
   input wire logic rx_timeout_in,
   // DMA pins and status
   output logic tx_dma_ready_n_out,
   output logic rx_dma_ready_n_out,
   output logic rx_trigger_out,
   output logic fifo_enable_out,
   output logic dma_mode_out
);

   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(DEPTH + 1);

   // Trigger code to occupancy level
   function automatic logic [CNT_W-1:0] trig_level(input logic [1:0] sel);
      logic [7:0] lvl;
      lvl = UFDMA_TRIG_LVL_1;
      case (sel)
         UFDMA_TRIG_SEL_1: lvl = UFDMA_TRIG_LVL_1;
         UFDMA_TRIG_SEL_4: lvl = UFDMA_TRIG_LVL_4;
         UFDMA_TRIG_SEL_8: lvl = UFDMA_TRIG_LVL_8;
         UFDMA_TRIG_SEL_14: lvl = UFDMA_TRIG_LVL_14;
         default: lvl = UFDMA_TRIG_LVL_1;
      endcase
      return lvl[CNT_W-1:0];
   endfunction : trig_level

   logic rst_meta_ff;
   logic rst_sync_ff;
   ufdma_ctrl_s ctrl_ff;
   logic [UFDMA_DATA_W-1:0] tx_mem [DEPTH];
   logic [UFDMA_DATA_W-1:0] rx_mem [DEPTH];
   logic [PTR_W-1:0] tx_wptr_ff, tx_rptr_ff, rx_wptr_ff, rx_rptr_ff;
   logic [PTR_W-1:0] nxt_tx_wptr, nxt_tx_rptr, nxt_rx_wptr, nxt_rx_rptr;
   logic [CNT_W-1:0] tx_cnt_ff, rx_cnt_ff, nxt_tx_cnt, nxt_rx_cnt;
   logic [CNT_W-1:0] cap;
   logic [CNT_W-1:0] level;
   logic [UFDMA_DATA_W-1:0] nxt_tx_data;
   logic rx_dma_active_ff;
   logic nxt_rx_dma_active;
   logic tx_push, tx_pop, rx_push, rx_pop;
   logic ctrl_wr, hold_wr;

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   // Decoded strobes and the capacity of the current mode
   assign ctrl_wr = wr_in && (addr_in == UFDMA_OFS_CTRL);
   assign hold_wr = wr_in && (addr_in == UFDMA_OFS_HOLD);
   // Without FIFOs only the single holding register is in use
   assign cap = ctrl_ff.fifo_en ? CNT_W'(DEPTH) : CNT_W'(1);
   assign level = trig_level(ctrl_ff.rx_trig_sel);
   // Overflowing characters are dropped; overrun is flagged elsewhere
   assign tx_push = hold_wr && (tx_cnt_ff < cap) && !ctrl_ff.tx_flush;
   assign tx_pop = tx_pop_in && (tx_cnt_ff != '0) && !ctrl_ff.tx_flush;
   assign rx_push = rx_push_in && (rx_cnt_ff < cap)
      && !ctrl_ff.rx_flush;
   // Reading an empty holding register pops nothing and returns zero
   assign rx_pop = rd_in && (addr_in == UFDMA_OFS_HOLD) && (rx_cnt_ff != '0)
      && !ctrl_ff.rx_flush;

   // Control register; flush bits live for one cycle only
   always_ff @(posedge clock_in or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         ctrl_ff <= UFDMA_CTRL_RST;
      end else if (ctrl_wr && wr_data_in[0]) begin
         ctrl_ff.rx_trig_sel <= wr_data_in[7:6];
         ctrl_ff.unused <= 2'h0;
         ctrl_ff.dma_mode <= wr_data_in[3];
         // Turning the FIFOs on starts from empty queues
         ctrl_ff.tx_flush <= wr_data_in[2] | ~ctrl_ff.fifo_en;
         ctrl_ff.rx_flush <= wr_data_in[1] | ~ctrl_ff.fifo_en;
         ctrl_ff.fifo_en <= 1'b1;
      end else if (ctrl_wr) begin
         // Bit 0 clear: enable drops and both queues flush if they were on; other bits keep their value
         ctrl_ff.fifo_en <= 1'b0;
         ctrl_ff.tx_flush <= ctrl_ff.fifo_en;
         ctrl_ff.rx_flush <= ctrl_ff.fifo_en;
      end else begin
         // Flush pulses last one cycle, so software reads them back as zero
         ctrl_ff.tx_flush <= 1'b0;
         ctrl_ff.rx_flush <= 1'b0;
      end
   end

   // Transmit queue next state; a flush beats any push or pop
   always_comb begin
      nxt_tx_wptr = tx_wptr_ff;
      nxt_tx_rptr = tx_rptr_ff;
      nxt_tx_cnt = tx_cnt_ff;
      if (ctrl_ff.tx_flush) begin
         nxt_tx_wptr = '0;
         nxt_tx_rptr = '0;
         nxt_tx_cnt = '0;
      end else begin
         if (tx_push) begin
            nxt_tx_wptr = tx_wptr_ff + PTR_W'(1);
         end
         if (tx_pop) begin
            nxt_tx_rptr = tx_rptr_ff + PTR_W'(1);
         end
         nxt_tx_cnt = tx_cnt_ff + CNT_W'(tx_push) - CNT_W'(tx_pop);
      end
   end

   // Head of the transmit queue, bypassing a word written this cycle
   always_comb begin
      if (tx_push && (nxt_tx_cnt == CNT_W'(1))) begin
         nxt_tx_data = wr_data_in;
      end else begin
         nxt_tx_data = tx_mem[nxt_tx_rptr];
      end
   end

   // Transmit queue pointers and count
   always_ff @(posedge clock_in or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         tx_wptr_ff <= '0;
         tx_rptr_ff <= '0;
         tx_cnt_ff <= '0;
      end else begin
         tx_wptr_ff <= nxt_tx_wptr;
         tx_rptr_ff <= nxt_tx_rptr;
         tx_cnt_ff <= nxt_tx_cnt;
      end
   end

   // Storage array needs no reset; contents are gated by the count
   always_ff @(posedge clock_in) begin
      if (tx_push) begin
         tx_mem[tx_wptr_ff] <= wr_data_in;
      end
      if (rx_push) begin
         rx_mem[rx_wptr_ff] <= rx_data_in;
      end
   end

   // Receive queue next state; a flush beats any push or pop
   always_comb begin
      nxt_rx_wptr = rx_wptr_ff;
      nxt_rx_rptr = rx_rptr_ff;
      nxt_rx_cnt = rx_cnt_ff;
      if (ctrl_ff.rx_flush) begin
         nxt_rx_wptr = '0;
         nxt_rx_rptr = '0;
         nxt_rx_cnt = '0;
      end else begin
         if (rx_push) begin
            nxt_rx_wptr = rx_wptr_ff + PTR_W'(1);
         end
         if (rx_pop) begin
            nxt_rx_rptr = rx_rptr_ff + PTR_W'(1);
         end
         nxt_rx_cnt = rx_cnt_ff + CNT_W'(rx_push) - CNT_W'(rx_pop);
      end
   end

   // Receive queue pointers and count
   always_ff @(posedge clock_in or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         rx_wptr_ff <= '0;
         rx_rptr_ff <= '0;
         rx_cnt_ff <= '0;
      end else begin
         rx_wptr_ff <= nxt_rx_wptr;
         rx_rptr_ff <= nxt_rx_rptr;
         rx_cnt_ff <= nxt_rx_cnt;
      end
   end

   // Block-mode receive request: empty clears, level or time-out sets
   always_comb begin
      nxt_rx_dma_active = rx_dma_active_ff;
      if (nxt_rx_cnt == '0) begin
         nxt_rx_dma_active = 1'b0;
      end else if ((nxt_rx_cnt >= level) || rx_timeout_in) begin
         nxt_rx_dma_active = 1'b1;
      end
   end

   // Request latch; holds past the level until the queue drains
   always_ff @(posedge clock_in or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         rx_dma_active_ff <= 1'b0;
      end else begin
         rx_dma_active_ff <= nxt_rx_dma_active;
      end
   end

   // Pins are built from next-state so they track the counts exactly
   always_ff @(posedge clock_in or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         tx_dma_ready_n_out <= 1'b0;
         rx_dma_ready_n_out <= 1'b1;
         rx_trigger_out <= 1'b0;
      end else if (ctrl_ff.fifo_en && ctrl_ff.dma_mode) begin
         // Block mode: ready follows a full queue and the request latch
         tx_dma_ready_n_out <= (nxt_tx_cnt == CNT_W'(DEPTH));
         rx_dma_ready_n_out <= ~nxt_rx_dma_active;
         rx_trigger_out <= (nxt_rx_cnt >= level);
      end else begin
         tx_dma_ready_n_out <= (nxt_tx_cnt != '0);
         rx_dma_ready_n_out <= (nxt_rx_cnt == '0);
         // Trigger event exists only in FIFO mode
         rx_trigger_out <= ctrl_ff.fifo_en && (nxt_rx_cnt >= level);
      end
   end

   // Shifter side view of the transmit head and mode status
   always_ff @(posedge clock_in or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         tx_data_out <= UFDMA_RDATA_RST;
         tx_valid_out <= 1'b0;
         fifo_enable_out <= 1'b0;
         dma_mode_out <= 1'b0;
      end else begin
         tx_data_out <= nxt_tx_data;
         tx_valid_out <= (nxt_tx_cnt != '0);
         fifo_enable_out <= ctrl_ff.fifo_en;
         dma_mode_out <= ctrl_ff.dma_mode;
      end
   end

   // Read data stands only in the cycle after the read strobe
   always_ff @(posedge clock_in or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         rd_data_out <= UFDMA_RDATA_RST;
      end else if (rd_in) begin
         case (addr_in)
            UFDMA_OFS_HOLD: rd_data_out <= rx_pop ? rx_mem[rx_rptr_ff]
               : UFDMA_RDATA_RST;
            UFDMA_OFS_CTRL: rd_data_out <= ctrl_ff;
            UFDMA_OFS_RXCNT: rd_data_out <= UFDMA_DATA_W'(rx_cnt_ff);
            UFDMA_OFS_TXCNT: rd_data_out <= UFDMA_DATA_W'(tx_cnt_ff);
            UFDMA_OFS_FLAGS: begin
               // Snapshot of the registered pins and queue states
               rd_data_out <= UFDMA_RDATA_RST;
               rd_data_out[UFDMA_FLAG_TRIG] <= rx_trigger_out;
               rd_data_out[UFDMA_FLAG_RX_RDY_N] <= rx_dma_ready_n_out;
               rd_data_out[UFDMA_FLAG_TX_RDY_N] <= tx_dma_ready_n_out;
               rd_data_out[UFDMA_FLAG_FIFO_EN] <= ctrl_ff.fifo_en;
               rd_data_out[UFDMA_FLAG_DMA_MODE] <= ctrl_ff.dma_mode;
               rd_data_out[UFDMA_FLAG_TX_FULL] <= (tx_cnt_ff == cap);
               rd_data_out[UFDMA_FLAG_RX_FULL] <= (rx_cnt_ff == cap);
            end
            // Unmapped offsets read as zero
            default: rd_data_out <= UFDMA_RDATA_RST;
         endcase
      end else begin
         rd_data_out <= UFDMA_RDATA_RST;
      end
   end

endmodule : ufdma_top

`default_nettype wire

// file: tb/ufdma_chk.sv
// Port assertions for the FIFO control and DMA ready block
`timescale 1ns/1ps
`default_nettype none
module ufdma_chk
   import ufdma_pkg::*;
(
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_n_in,
   // Register port
   input wire logic [UFDMA_ADDR_W-1:0] addr_in,
   input wire logic [UFDMA_DATA_W-1:0] wr_data_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [UFDMA_DATA_W-1:0] rd_data_out,
   // Queue side and pins
   input wire logic rx_push_in,
   input wire logic tx_valid_out,
   input wire logic tx_dma_ready_n_out,
   input wire logic rx_dma_ready_n_out,
   input wire logic rx_trigger_out,
   input wire logic fifo_enable_out,
   input wire logic dma_mode_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   logic m1, rx0, wc;
   // Mode terms; checks want them settled a cycle, as pins lag writes
   assign m1 = fifo_enable_out && dma_mode_out;
   assign rx0 = fifo_enable_out && !dma_mode_out;
   assign wc = wr_in && addr_in == UFDMA_OFS_CTRL;

   AST_UNUSED_ZERO: assert property (
      rd_in && addr_in == UFDMA_OFS_CTRL |=> rd_data_out[5:4] == 2'h0)
      else $error("unused control bits read nonzero");
   AST_TX_MODE0: assert property (
      !m1 && !$past(m1) |-> tx_dma_ready_n_out == tx_valid_out)
      else $error("transmit ready wrong in mode 0");
   AST_RX_MODE0: assert property (
      !m1 && !$past(m1) && rx_push_in && !rd_in && !wr_in && !$past(wr_in)
      |=> !rx_dma_ready_n_out) else $error("receive ready not low");
   AST_TX_MODE1: assert property (
      m1 && $past(m1) && !tx_valid_out |-> !tx_dma_ready_n_out)
      else $error("block transmit ready high with free room");
   AST_RX_HOLD: assert property (
      m1 && $past(m1) && !rx_dma_ready_n_out && !rd_in && !$past(rd_in)
      && !wr_in && !$past(wr_in) |=> !rx_dma_ready_n_out)
      else $error("block receive ready released early");
   AST_TRIG_READY: assert property (
      rx0 && $past(rx0) && rx_trigger_out |-> !rx_dma_ready_n_out)
      else $error("trigger without held character");
   AST_SELF_CLEAR: assert property (
      wc ##1 !wr_in ##1 (rd_in && addr_in == UFDMA_OFS_CTRL)
      |=> rd_data_out[2:1] == 2'h0) else $error("flush bits stuck");
   AST_COPY: assert property (
      wc && wr_data_in[0] |-> ##2 fifo_enable_out
      && dma_mode_out == $past(wr_data_in[3], 2))
      else $error("enable or mode copy wrong");
   AST_LOCKED: assert property (
      wc && !wr_data_in[0] |-> ##2 !fifo_enable_out && $stable(dma_mode_out))
      else $error("mode changed without enable");
endmodule : ufdma_chk

bind ufdma_top ufdma_chk u_chk (.clock_in, .rst_n_in, .addr_in,
   .wr_data_in, .wr_in, .rd_in, .rd_data_out, .rx_push_in, .tx_valid_out,
   .tx_dma_ready_n_out, .rx_dma_ready_n_out, .rx_trigger_out,
   .fifo_enable_out, .dma_mode_out);
`default_nettype wire

// file: tb/ufdma_shift_model.sv
// Behavioural model of the serial shift registers beside the queues
`timescale 1ns/1ps
`default_nettype none
module ufdma_shift_model (
   // Clock and bench controls
   input wire logic clock_in,
   input wire logic send_in,
   input wire logic drain_in,
   // Queue side of the block
   input wire logic tx_valid_in,
   output logic tx_pop_out,
   output logic rx_push_out,
   output logic [7:0] rx_data_out
);
   // First number matches the bench's expectation counter
   logic [7:0] seq_ff = 8'h30;
   // Transmitter takes a character each cycle unless stalled
   assign tx_pop_out = drain_in && tx_valid_in;
   // Numbered characters; idle data keeps moving so it is never trusted
   always @(posedge clock_in) begin
      rx_push_out <= send_in;
      rx_data_out <= send_in ? seq_ff : ~rx_data_out;
      if (send_in) begin
         seq_ff <= seq_ff + 8'h01;
      end
   end
endmodule : ufdma_shift_model
`default_nettype wire

// file: tb/test_uart_fifo_dma_ready_control.sv
// Self-checking bench for the FIFO control and DMA ready block
`timescale 1ns/1ps
`default_nettype none
module test_uart_fifo_dma_ready_control
   import ufdma_pkg::*;
;
   logic clock_in, rst_n_in, wr_in, rd_in, rx_push_in, rx_timeout_in;
   logic send, drain, tx_pop_in, tx_valid_out, tx_dma_ready_n_out;
   logic rx_dma_ready_n_out, rx_trigger_out, fifo_enable_out, dma_mode_out;
   logic [2:0] addr_in;
   logic [7:0] wr_data_in, rd_data_out, tx_data_out, rx_data_in, rxn, got, e;
   int mismatches, checks, cyc;
   int lv[4] = '{1, 4, 8, 14};

   ufdma_top #(.DEPTH(16)) u_dut (.clock_in, .rst_n_in, .addr_in,
      .wr_data_in, .wr_in, .rd_in, .rd_data_out, .tx_pop_in, .tx_data_out,
      .tx_valid_out, .rx_push_in, .rx_data_in, .rx_timeout_in,
      .tx_dma_ready_n_out, .rx_dma_ready_n_out, .rx_trigger_out,
      .fifo_enable_out, .dma_mode_out);
   ufdma_shift_model u_shift (.clock_in, .send_in(send), .drain_in(drain),
      .tx_valid_in(tx_valid_out), .tx_pop_out(tx_pop_in),
      .rx_push_out(rx_push_in), .rx_data_out(rx_data_in));

   // 25 MHz clock
   initial begin
      clock_in = 1'b0;
      forever #20 clock_in = ~clock_in;
   end
   // Hang guard, several times the expected run
   always @(posedge clock_in) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         mismatches++;
         print_verdict();
      end
   end

   task automatic chk(input logic [7:0] g, input logic [7:0] x, string m);
      checks++;
      if (g !== x) begin
         mismatches++;
         $display("FAIL %0t %s got %h exp %h", $time, m, g, x);
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wr_data_in <= d;
      @(posedge clock_in);
      wr_in <= 1'b0;
      @(negedge clock_in);
   endtask : wr
   task automatic rd(input logic [2:0] a);
      @(posedge clock_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clock_in);
      rd_in <= 1'b0;
      @(negedge clock_in);
      got = rd_data_out;
   endtask : rd
   // Partner delivers one character, taken two edges later
   task automatic rx_one;
      @(posedge clock_in);
      send <= 1'b1;
      @(posedge clock_in);
      send <= 1'b0;
      @(posedge clock_in);
      @(negedge clock_in);
      rxn++;
   endtask : rx_one
   task automatic pop1;
      @(posedge clock_in);
      drain <= 1'b1;
      @(posedge clock_in);
      drain <= 1'b0;
      @(negedge clock_in);
   endtask : pop1
   task automatic idle;
      @(posedge clock_in);
      @(negedge clock_in);
   endtask : idle

   task automatic t_reset;
      wr(3'h6, 8'hFF);
      rd(UFDMA_OFS_CTRL);
      chk(got, 8'h00, "control reset");
      rd(UFDMA_OFS_FLAGS);
      chk(got, 8'h02, "flags reset");
      rd(3'h5);
      chk(got, 8'h00, "unmapped read");
      $display("test reset done");
   endtask : t_reset
   // No queues: one character each way, extras dropped
   task automatic t_mode0;
      wr(UFDMA_OFS_HOLD, 8'hA5);
      chk(tx_dma_ready_n_out, 1'b1, "tx ready after load");
      chk(tx_valid_out, 1'b1, "tx valid after load");
      wr(UFDMA_OFS_HOLD, 8'h5A);
      chk(tx_data_out, 8'hA5, "tx head");
      pop1();
      chk(tx_dma_ready_n_out, 1'b0, "tx ready when empty");
      chk(tx_valid_out, 1'b0, "tx valid when empty");
      e = rxn;
      rx_one();
      chk(rx_dma_ready_n_out, 1'b0, "rx ready held");
      rx_one();
      rd(UFDMA_OFS_HOLD);
      chk(got, e, "rx char");
      chk(rx_dma_ready_n_out, 1'b1, "rx ready empty");
      chk(rx_trigger_out, 1'b0, "no trigger unqueued");
      $display("test mode0 done");
   endtask : t_mode0
   task automatic t_ctrl;
      wr(UFDMA_OFS_CTRL, 8'hFF);
      rd(UFDMA_OFS_CTRL);
      chk(got, 8'hC9, "control readback");
      chk(fifo_enable_out, 1'b1, "enable copy");
      wr(UFDMA_OFS_CTRL, 8'h00);
      rd(UFDMA_OFS_CTRL);
      chk(got, 8'hC8, "bits kept when disabled");
      chk(dma_mode_out, 1'b1, "mode kept");
      $display("test control done");
   endtask : t_ctrl
   // Every trigger code: fill past full, then drain in order
   task automatic t_trig;
      for (int s = 0; s < 4; s++) begin
         wr(UFDMA_OFS_CTRL, {s[1:0], 6'h07});
         for (int n = 1; n <= 17; n++) begin
            rx_one();
            chk(rx_trigger_out, n >= lv[s], "trigger on fill");
         end
         rd(UFDMA_OFS_RXCNT);
         chk(got, 8'h10, "rx full count");
         rd(UFDMA_OFS_FLAGS);
         chk(got, 8'h49, "flags when full");
         e = rxn - 8'h11;
         for (int n = 15; n >= 0; n--) begin
            rd(UFDMA_OFS_HOLD);
            chk(got, e, "rx order");
            e++;
            chk(rx_trigger_out, n >= lv[s], "trigger falls");
         end
         chk(rx_dma_ready_n_out, 1'b1, "rx ready empty");
      end
      $display("test trigger done");
   endtask : t_trig
   task automatic t_mode1;
      wr(UFDMA_OFS_CTRL, 8'h4F);
      for (int n = 1; n <= 17; n++) begin
         wr(UFDMA_OFS_HOLD, n[7:0]);
         chk(tx_dma_ready_n_out, n >= 16, "block tx ready");
      end
      pop1();
      chk(tx_dma_ready_n_out, 1'b0, "one free slot");
      wr(UFDMA_OFS_CTRL, 8'h4D);
      rd(UFDMA_OFS_TXCNT);
      chk(got, 8'h00, "tx flushed");
      repeat (3) rx_one();
      chk(rx_dma_ready_n_out, 1'b1, "below trigger");
      chk(rx_trigger_out, 1'b0, "block below level");
      @(posedge clock_in);
      rx_timeout_in <= 1'b1;
      @(posedge clock_in);
      rx_timeout_in <= 1'b0;
      idle();
      chk(rx_dma_ready_n_out, 1'b0, "time-out request");
      repeat (2) rd(UFDMA_OFS_HOLD);
      chk(rx_dma_ready_n_out, 1'b0, "held until empty");
      rd(UFDMA_OFS_HOLD);
      idle();
      chk(rx_dma_ready_n_out, 1'b1, "released when empty");
      repeat (4) rx_one();
      idle();
      chk(rx_dma_ready_n_out, 1'b0, "trigger request");
      chk(rx_trigger_out, 1'b1, "block trigger");
      wr(UFDMA_OFS_CTRL, 8'h4B);
      rd(UFDMA_OFS_RXCNT);
      chk(got, 8'h00, "rx flushed");
      $display("test mode1 done");
   endtask : t_mode1

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : print_verdict

   initial begin
      {rst_n_in, wr_in, rd_in, send, drain, rx_timeout_in} = 6'h00;
      addr_in = 3'h0;
      wr_data_in = 8'h00;
      rxn = 8'h30;
      repeat (4) @(posedge clock_in);
      rst_n_in <= 1'b1;
      repeat (4) @(posedge clock_in);
      t_reset();
      t_mode0();
      t_ctrl();
      t_trig();
      t_mode1();
      print_verdict();
   end
endmodule : test_uart_fifo_dma_ready_control
`default_nettype wire
